// ### pkg/tes_pkg.sv
// constants, field layouts and state carrier of the encoder/slave-mode front end
// assumes a 10 MHz timer clock and an avalon-mm register port with byte addresses
package tes_pkg;

  localparam int CNT_W = 16;
  localparam int N_IN = 4;
  localparam int ADDR_W = 5;

  // byte offsets of the register words
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CAPT = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h10;

  // input slots of the synchroniser and filter
  localparam int IN_CH0 = 0;
  localparam int IN_CH1 = 1;
  localparam int IN_CH2 = 2;
  localparam int IN_EXT = 3;

  // status bit positions
  localparam int STAT_CAPT = 0;
  localparam int STAT_TRIG = 1;
  localparam int STAT_COMM = 2;
  localparam int STAT_W = 3;
  localparam int DIR_BIT = 16;

  // slave mode select codes
  localparam logic [2:0] SM_OFF = 3'h0;
  localparam logic [2:0] SM_ENC0 = 3'h1;
  localparam logic [2:0] SM_ENC1 = 3'h2;
  localparam logic [2:0] SM_ENC01 = 3'h3;
  localparam logic [2:0] SM_RESTART = 3'h4;
  localparam logic [2:0] SM_PAUSE = 3'h5;
  localparam logic [2:0] SM_EVENT = 3'h6;
  localparam logic [2:0] SM_EXTCLK = 3'h7;

  // trigger source select codes with bit 2 set; below that, internal triggers 0 to 3
  localparam logic [1:0] TS_EDGE0 = 2'h0;
  localparam logic [1:0] TS_FE0 = 2'h1;
  localparam logic [1:0] TS_FE1 = 2'h2;
  localparam logic [1:0] TS_EXT = 2'h3;

  localparam logic [CNT_W-1:0] RELOAD_RST = 16'hffff;

  // control word, bit 0 at the bottom
  typedef struct packed {
    logic [3:0] channel_capture_filter;
    logic commutation_shadow_enable;
    logic commutation_update_control;
    logic ch1_channel_inverse_polarity;
    logic ch1_channel_polarity;
    logic ch0_channel_inverse_polarity;
    logic ch0_channel_polarity;
    logic [1:0] trigger_prescale;
    logic external_trigger_polarity;
    logic xor_input_select;
    logic [2:0] trigger_source_select;
    logic [2:0] slave_mode_select;
    logic counter_enable;
  } tes_ctrl_t;

  localparam int CTRL_W = $bits(tes_ctrl_t);

  typedef struct packed {
    tes_ctrl_t ctrl;
    logic [CNT_W-1:0] reload;
    logic [CNT_W-1:0] count;
    logic dir;
    logic [CNT_W-1:0] capture;
    logic [STAT_W-1:0] stat;
    logic [N_IN-1:0] sync1;
    logic [N_IN-1:0] sync2;
    logic [N_IN-1:0] sync3;
    logic [N_IN-1:0] lvl;
    logic [N_IN-1:0][3:0] fcnt;
    logic fe0_prev;
    logic fe1_prev;
    logic ci0_prev;
    logic ext_prev;
    logic [3:0] itr_prev;
    logic [2:0] ext_div;
    logic waitreq;
    logic [31:0] rdata;
    logic trig_pulse;
    logic comm_pulse;
  } tes_state_t;

endpackage

// ### rtl/tes_timer_slave.sv
// encoder, trigger selector and slave-mode counter of the timer front end
// assumes pins arrive asynchronously, internal triggers on clk, and an avalon-mm master
//
// Overview of operation
// [R1] encoder inputs come from filtered channel 0 and channel 1 pins
// [R2] slave mode codes 1, 2, 3 count on channel 0, channel 1 or both
// [R3] direction bit updates on every counted encoder transition
// [R4] encoder counts like a directional clock, wrapping between 0 and reload
// [R5] software loads the reload value before starting encoder counting
// [R6] direction follows edge type of one input and level of the other
// [R7] single-input encoder modes ignore edges on the other input
// [R8] xor select: any change on three inputs toggles channel 0, which captures count
// [R9] commutation control and shadow bits let an internal trigger commute directly
// [R10] restart clears on rising trigger, pause halts while low, event starts count
// [R11] trigger select: internal 0-3, edge detector, channel 0, channel 1, external
// [R12] external trigger uses its polarity bit, channels use their polarity bits
// [R13] internal triggers pass with no polarity, filter or prescale
// [R14] prescale setting one halves the external trigger edge rate
// [R15] slave mode code 6 is event mode, trigger edge starts counting
// [R16] slave mode code 4 is restart mode
`timescale 1ns/1ps
`default_nettype none

module tes_timer_slave
  import tes_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ch0_pin,
  input wire logic ch1_pin,
  input wire logic ch2_pin,
  input wire logic ext_trigger_pin,
  input wire logic [3:0] internal_trigger_input,
  output logic [CNT_W-1:0] count_value,
  output logic count_dir,
  output logic [CNT_W-1:0] channel0_capture_value,
  output logic trigger_event,
  output logic commutation_event
);

  tes_state_t s;
  tes_state_t n;

  always_comb begin
    logic ci0;
    logic filtered_channel0_input;
    logic filtered_channel1_input;
    logic channel0_edge_detect;
    logic ch0_trig_edge;
    logic ch1_trig_edge;
    logic enc_edge0;
    logic enc_edge1;
    logic ext_lvl;
    logic ext_rise;
    logic filtered_external_trigger;
    logic [2:0] div_max;
    logic [3:0] itr_rise;
    logic trg_edge;
    logic trg_lvl;
    logic tick;
    logic down;
    logic clear;
    logic cap_ev;
    logic [31:0] wmask;
    logic [31:0] merged;
    ci0 = 1'b0;
    filtered_channel0_input = 1'b0;
    filtered_channel1_input = 1'b0;
    channel0_edge_detect = 1'b0;
    ch0_trig_edge = 1'b0;
    ch1_trig_edge = 1'b0;
    enc_edge0 = 1'b0;
    enc_edge1 = 1'b0;
    ext_lvl = 1'b0;
    ext_rise = 1'b0;
    filtered_external_trigger = 1'b0;
    div_max = 3'h0;
    itr_rise = 4'h0;
    trg_edge = 1'b0;
    trg_lvl = 1'b0;
    tick = 1'b0;
    down = 1'b0;
    clear = 1'b0;
    cap_ev = 1'b0;
    wmask = 32'h0;
    merged = 32'h0;
    n = s;

    // three-stage synchroniser; only stages two and three feed the filter
    n.sync1 = {ext_trigger_pin, ch2_pin, ch1_pin, ch0_pin}; // [R1]
    n.sync2 = s.sync1;
    n.sync3 = s.sync2;
    for (int i = 0; i < N_IN; i++) begin
      if (s.sync2[i] == s.sync3[i] && s.sync3[i] != s.lvl[i]) begin
        if (s.fcnt[i] >= s.ctrl.channel_capture_filter) begin
          n.lvl[i] = s.sync3[i];
          n.fcnt[i] = 4'h0;
        end else begin
          n.fcnt[i] = s.fcnt[i] + 4'h1;
        end
      end else begin
        n.fcnt[i] = 4'h0;
      end
    end

    // channel 0 either plain or the xor of all three hall inputs
    ci0 = s.ctrl.xor_input_select ? ^s.lvl[IN_CH2:IN_CH0] : s.lvl[IN_CH0]; // [R8]
    filtered_channel0_input = ci0 ^ s.ctrl.ch0_channel_polarity; // [R12]
    filtered_channel1_input = s.lvl[IN_CH1] ^ s.ctrl.ch1_channel_polarity; // [R12]
    n.ci0_prev = ci0;
    n.fe0_prev = filtered_channel0_input;
    n.fe1_prev = filtered_channel1_input;
    channel0_edge_detect = ci0 ^ s.ci0_prev;
    enc_edge0 = filtered_channel0_input ^ s.fe0_prev;
    enc_edge1 = filtered_channel1_input ^ s.fe1_prev;
    // inverse polarity bit set means both edges are active, whatever the polarity bit
    ch0_trig_edge = s.ctrl.ch0_channel_inverse_polarity ? enc_edge0 :
                    (filtered_channel0_input & ~s.fe0_prev); // [R12]
    ch1_trig_edge = s.ctrl.ch1_channel_inverse_polarity ? enc_edge1 :
                    (filtered_channel1_input & ~s.fe1_prev); // [R12]

    // external trigger: polarity, then edge prescaler of 1, 2, 4 or 8
    ext_lvl = s.lvl[IN_EXT] ^ s.ctrl.external_trigger_polarity; // [R12]
    n.ext_prev = ext_lvl;
    ext_rise = ext_lvl & ~s.ext_prev;
    div_max = 3'((4'h1 << s.ctrl.trigger_prescale) - 4'h1);
    if (ext_rise) begin
      if (s.ext_div >= div_max) begin // [R14]
        n.ext_div = 3'h0;
        filtered_external_trigger = 1'b1;
      end else begin
        n.ext_div = s.ext_div + 3'h1;
      end
    end

    // internal triggers are taken as they come, no conditioning
    n.itr_prev = internal_trigger_input;
    itr_rise = internal_trigger_input & ~s.itr_prev; // [R13]

    if (!s.ctrl.trigger_source_select[2]) begin
      trg_edge = itr_rise[s.ctrl.trigger_source_select[1:0]]; // [R11]
      trg_lvl = internal_trigger_input[s.ctrl.trigger_source_select[1:0]]; // [R13]
    end else begin
      unique case (s.ctrl.trigger_source_select[1:0]) // [R11]
        TS_EDGE0: begin
          trg_edge = channel0_edge_detect;
          trg_lvl = ci0;
        end
        TS_FE0: begin
          trg_edge = ch0_trig_edge;
          trg_lvl = filtered_channel0_input;
        end
        TS_FE1: begin
          trg_edge = ch1_trig_edge;
          trg_lvl = filtered_channel1_input;
        end
        TS_EXT: begin
          trg_edge = filtered_external_trigger;
          trg_lvl = ext_lvl;
        end
      endcase
    end

    // register port: one wait cycle, then the access completes
    n.waitreq = ~((avs_read | avs_write) & s.waitreq);
    if (avs_read && s.waitreq) begin
      unique case (avs_address)
        OFS_CTRL: n.rdata = 32'(s.ctrl);
        OFS_RELOAD: n.rdata = 32'(s.reload);
        OFS_COUNT: n.rdata = 32'(s.count) | (32'(s.dir) << DIR_BIT);
        OFS_CAPT: n.rdata = 32'(s.capture);
        OFS_STAT: n.rdata = 32'(s.stat);
        default: n.rdata = 32'h0;
      endcase
    end
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    if (avs_write && !s.waitreq) begin
      unique case (avs_address)
        OFS_CTRL: begin
          merged = (32'(s.ctrl) & ~wmask) | (avs_writedata & wmask);
          n.ctrl = tes_ctrl_t'(merged[CTRL_W-1:0]);
        end
        OFS_RELOAD: begin
          merged = (32'(s.reload) & ~wmask) | (avs_writedata & wmask);
          n.reload = merged[CNT_W-1:0];
        end
        OFS_STAT: n.stat = s.stat & ~(avs_writedata[STAT_W-1:0] & wmask[STAT_W-1:0]);
        default: begin
        end
      endcase
    end

    // counting; hardware sets below override a same-cycle software write
    unique case (s.ctrl.slave_mode_select) // [R2]
      SM_ENC0: begin
        tick = s.ctrl.counter_enable & enc_edge0; // [R7]
        down = ~(filtered_channel0_input ^ filtered_channel1_input); // [R6]
      end
      SM_ENC1: begin
        tick = s.ctrl.counter_enable & enc_edge1; // [R7]
        down = filtered_channel0_input ^ filtered_channel1_input; // [R6]
      end
      SM_ENC01: begin
        tick = s.ctrl.counter_enable & (enc_edge0 | enc_edge1);
        // simultaneous edges cannot come from a real encoder; channel 0 wins
        down = enc_edge0 ? ~(filtered_channel0_input ^ filtered_channel1_input) :
               (filtered_channel0_input ^ filtered_channel1_input); // [R6]
      end
      SM_RESTART: begin
        tick = s.ctrl.counter_enable; // [R16]
        clear = trg_edge; // [R10]
      end
      SM_PAUSE: tick = s.ctrl.counter_enable & trg_lvl; // [R10]
      SM_EVENT: begin
        if (trg_edge) begin
          n.ctrl.counter_enable = 1'b1; // [R15]
        end
        tick = s.ctrl.counter_enable; // [R10]
      end
      SM_EXTCLK: tick = s.ctrl.counter_enable & trg_edge;
      default: tick = s.ctrl.counter_enable;
    endcase

    if (clear) begin
      n.count = '0;
      n.dir = 1'b0;
    end else if (tick) begin
      n.dir = down; // [R3]
      // reload must be set before counting starts, or the wrap point is stale
      if (down) begin
        n.count = (s.count == '0) ? s.reload : s.count - 16'h1; // [R4] [R5]
      end else begin
        n.count = (s.count >= s.reload) ? '0 : s.count + 16'h1; // [R4]
      end
    end

    // channel 0 capture; with xor every hall change counts
    cap_ev = s.ctrl.xor_input_select ? channel0_edge_detect : ch0_trig_edge; // [R8]
    if (cap_ev) begin
      n.capture = s.count; // [R8]
      n.stat[STAT_CAPT] = 1'b1;
    end

    n.trig_pulse = trg_edge & (s.ctrl.slave_mode_select != SM_OFF);
    if (n.trig_pulse) begin
      n.stat[STAT_TRIG] = 1'b1;
    end

    n.comm_pulse = s.ctrl.commutation_update_control & s.ctrl.commutation_shadow_enable &
                   ~s.ctrl.trigger_source_select[2] & trg_edge; // [R9]
    if (n.comm_pulse) begin
      n.stat[STAT_COMM] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.reload <= RELOAD_RST;
      s.waitreq <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign count_value = s.count;
  assign count_dir = s.dir;
  assign channel0_capture_value = s.capture;
  assign trigger_event = s.trig_pulse;
  assign commutation_event = s.comm_pulse;

endmodule

`default_nettype wire

// ### bench/tes_timer_slave_props.sv
// checker: bus handshake, trigger, slave-mode and encoder relations
// assumes bound to tes_timer_slave; control and reload mirrored from full-word writes
`timescale 1ns/1ps
`default_nettype none
module tes_timer_slave_props
  import tes_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [3:0] internal_trigger_input,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic count_dir,
  input wire logic trigger_event,
  input wire logic commutation_event
);
  tes_ctrl_t ctl_r;
  logic [CNT_W-1:0] rld_r;
  logic its;
  logic intl;
  logic enc;
  assign its = internal_trigger_input[ctl_r.trigger_source_select[1:0]];
  assign intl = !ctl_r.trigger_source_select[2];
  assign enc = ctl_r.slave_mode_select inside {SM_ENC0, SM_ENC1, SM_ENC01};
  // byte lanes ignored: the bench always writes whole words
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_r <= '0;
      rld_r <= RELOAD_RST;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == OFS_CTRL) ctl_r <= avs_writedata[CTRL_W-1:0];
      if (avs_address == OFS_RELOAD) rld_r <= avs_writedata[CNT_W-1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered");
  chk_bus_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  chk_trig_internal: assert property (ctl_r.slave_mode_select != SM_OFF && intl && $rose(its) |=> trigger_event)
    else $error("internal trigger lost");
  chk_comm_direct: assert property (ctl_r.commutation_update_control && ctl_r.commutation_shadow_enable
    && intl && $rose(its) |=> commutation_event) else $error("commutation lost");
  chk_restart_clear: assert property (ctl_r.slave_mode_select == SM_RESTART && trigger_event
    |-> count_value == '0 && !count_dir) else $error("restart not cleared");
  chk_pause_hold: assert property ((ctl_r.slave_mode_select == SM_PAUSE && intl && !its)[*2]
    |=> $stable(count_value)) else $error("count moved in pause");
  chk_event_start: assert property (ctl_r.slave_mode_select == SM_EVENT && trigger_event
    |-> ##[1:2] !$stable(count_value)) else $error("event did not start");
  chk_enc_step: assert property (enc && $changed(count_value) |-> count_value == $past(count_value) + 16'h1
    || count_value == $past(count_value) - 16'h1 || count_value == '0 || count_value == rld_r)
    else $error("encoder step out of range");
endmodule
bind tes_timer_slave tes_timer_slave_props chk_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .internal_trigger_input(internal_trigger_input), .count_value(count_value), .count_dir(count_dir),
  .trigger_event(trigger_event), .commutation_event(commutation_event));
`default_nettype wire

// ### bench/tes_enc_model.sv
// encoder and hall sensor stand-in driving the three channel pins
// assumes step and hall are one-cycle strobes on clk
`timescale 1ns/1ps
`default_nettype none
module tes_enc_model (
  input wire logic clk,
  input wire logic step,
  input wire logic up,
  input wire logic hall,
  output logic ch0,
  output logic ch1,
  output var logic ch2
);
  logic [1:0] ph_r = 2'h0;
  // gray order 00,10,11,01: channel 0 leads when turning up
  assign ch0 = ph_r == 2'h1 || ph_r == 2'h2;
  assign ch1 = ph_r[1];
  initial ch2 = 1'b0;
  always @(posedge clk) begin
    if (step) ph_r <= up ? ph_r + 2'h1 : ph_r - 2'h1;
    if (hall) ch2 <= !ch2;
  end
endmodule
`default_nettype wire

// ### bench/tes_timer_slave_tb.sv
// self-checking bench: registers, encoder modes, triggers, pause, event, hall capture
// assumes the encoder model on the pins and a 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tes_timer_slave_tb
  import tes_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst_n, rd, wr, stp, up, hl, ext, ch0, ch1, ch2, wreq, dir_o, tev, cev;
  logic [ADDR_W-1:0] adr;
  logic [31:0] wdat, rdat, got;
  logic [3:0] itr;
  logic [CNT_W-1:0] cnt_o, cap_o, v;
  tes_ctrl_t c;
  int fail_count, num_checks, cyc, n_trig, n_comm, nt, nc, cnt, dir, ph, md;
  int rl = 5;
  always #50 clk = !clk;
  tes_enc_model enc_u (.clk(clk), .step(stp), .up(up), .hall(hl), .ch0(ch0), .ch1(ch1), .ch2(ch2));
  tes_timer_slave dut_u (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq), .ch0_pin(ch0),
    .ch1_pin(ch1), .ch2_pin(ch2), .ext_trigger_pin(ext), .internal_trigger_input(itr), .count_value(cnt_o),
    .count_dir(dir_o), .channel0_capture_value(cap_o), .trigger_event(tev), .commutation_event(cev));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wreq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic step(input int u);
    int p0;
    bit e0;
    p0 = ph;
    ph = (ph + (u ? 1 : 3)) % 4;
    e0 = (p0 + ph) % 4 == 1;
    if (md == 3 || (md == 1 && e0) || (md == 2 && !e0)) begin
      dir = !u;
      cnt = u ? (cnt >= rl ? 0 : cnt + 1) : (cnt == 0 ? rl : cnt - 1);
    end
    stp <= 1'b1;
    up <= 1'(u);
    @(posedge clk);
    stp <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic pulse(input logic [3:0] m);
    itr <= m;
    repeat (2) @(posedge clk);
    itr <= '0;
    repeat (4) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (tev) n_trig++;
    if (cev) n_comm++;
    if (cyc == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    {rst_n, rd, wr, stp, up, hl, ext, adr, wdat, itr} = '0;
    void'($urandom(17454));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1, OFS_COUNT, 32'h1234);
    bus(1, 5'h14, 32'hffffffff);
    for (int i = 0; i < 5; i++) begin
      bus(0, 5'(4 * i), 0);
      chk(got, i == 1 ? 32'hffff : 0);
    end
    bus(1, OFS_RELOAD, 32'(rl));
    for (md = 1; md <= 3; md++) begin
      c = '0;
      c.counter_enable = 1'b1;
      c.slave_mode_select = 3'(md);
      bus(1, OFS_CTRL, 32'(c));
      repeat (20) begin
        step($urandom_range(0, 1));
        chk(32'(cnt_o), 32'(cnt));
        chk(32'(dir_o), 32'(dir));
      end
    end
    bus(0, OFS_COUNT, 0);
    chk(got, 32'(cnt) | 32'(dir) << DIR_BIT);
    bus(1, OFS_RELOAD, 32'hffff);
    c.slave_mode_select = SM_RESTART;
    c.commutation_update_control = 1'b1;
    c.commutation_shadow_enable = 1'b1;
    for (int s = 0; s < 4; s++) begin
      c.trigger_source_select = 3'(s);
      bus(1, OFS_CTRL, 32'(c));
      nt = n_trig;
      nc = n_comm;
      pulse(4'h1 << ((s + 1) % 4));
      pulse(4'h1 << s);
      chk(n_trig - nt, 1);
      chk(n_comm - nc, 1);
    end
    // pin sources: one rising edge of each channel per full encoder turn
    for (int s = 5; s < 7; s++) begin
      c.trigger_source_select = 3'(s);
      bus(1, OFS_CTRL, 32'(c));
      nt = n_trig;
      repeat (4) step(1);
      chk(n_trig - nt, 1);
    end
    // all three sources have fired by now; flags clear by writing ones
    bus(0, OFS_STAT, 0);
    chk(got, 32'h7);
    bus(1, OFS_STAT, 32'h7);
    bus(0, OFS_STAT, 0);
    chk(got, 32'h0);
    c.slave_mode_select = SM_PAUSE;
    c.trigger_source_select = 3'h0;
    bus(1, OFS_CTRL, 32'(c));
    for (int k = 0; k < 2; k++) begin
      itr <= 4'(k);
      repeat (3) @(posedge clk);
      v = cnt_o;
      repeat (10) @(posedge clk);
      chk(32'(cnt_o), 32'(v + 16'(10 * k)));
    end
    itr <= '0;
    c.counter_enable = 1'b0;
    c.slave_mode_select = SM_EVENT;
    c.trigger_source_select = 3'h7;
    c.trigger_prescale = 2'h1;
    bus(1, OFS_CTRL, 32'(c));
    nt = n_trig;
    v = cnt_o;
    repeat (5) @(posedge clk);
    chk(32'(cnt_o), 32'(v));
    repeat (4) begin
      ext <= 1'b1;
      repeat (10) @(posedge clk);
      ext <= 1'b0;
      repeat (10) @(posedge clk);
    end
    chk(n_trig - nt, 2);
    v = cnt_o;
    repeat (5) @(posedge clk);
    chk(32'(cnt_o), 32'(v + 16'h5));
    c = '0;
    c.counter_enable = 1'b1;
    c.xor_input_select = 1'b1;
    bus(1, OFS_CTRL, 32'(c));
    for (int k = 0; k < 3; k++) begin
      v = cap_o;
      if (k == 0) begin
        hl <= 1'b1;
        @(posedge clk);
        hl <= 1'b0;
        repeat (8) @(posedge clk);
      end else step(k - 1);
      chk(32'(cap_o != v), 1);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
